/* File: rtl/pmx_pin_ctrl.sv */
// Per-pin pull, slew and drive control with shared-function arbitration.
// Assumes peripherals present per-pin requests and pin inputs are synchronous.
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_ctrl #(
  parameter int OUT_ONLY_PIN = 13,
  parameter int IN_ONLY_PIN = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [pmx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmx_pkg::DATA_W-1:0] reg_rdata,
  input wire pmx_pkg::pmx_fn_req_t [pmx_pkg::NUM_PINS-1:0] fn_req,
  input wire logic [pmx_pkg::NUM_PINS-1:0] key_rise_edge,
  input wire logic [pmx_pkg::NUM_PINS-1:0] adc_en,
  input wire logic [pmx_pkg::NUM_PINS-1:0] analog_compare_unit_en,
  input wire logic two_wire_en,
  input wire logic scl_oe,
  input wire logic scl_out,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic debug_oe,
  input wire logic debug_out,
  input wire logic [pmx_pkg::NUM_PINS-1:0] pad_in,
  output logic scl_in,
  output logic sda_in,
  output logic debug_in,
  output logic [pmx_pkg::NUM_PINS-1:0] adc_tap,
  output logic [pmx_pkg::NUM_PINS-1:0] analog_compare_unit_tap,
  output pmx_pkg::pmx_pad_ctl_t [pmx_pkg::NUM_PINS-1:0] pad_ctl,
  output logic [pmx_pkg::NUM_PINS-1:0][pmx_pkg::OWNER_W-1:0] pin_owner
);
  import pmx_pkg::*;

  // ************************************************************
  // Parameter checks
  // ************************************************************
  if (OUT_ONLY_PIN < 0 || OUT_ONLY_PIN >= NUM_PINS) begin : g_bad_out
    $error("OUT_ONLY_PIN outside the pin range");
  end
  if (IN_ONLY_PIN < 0 || IN_ONLY_PIN >= NUM_PINS || IN_ONLY_PIN == OUT_ONLY_PIN) begin : g_bad_in
    $error("IN_ONLY_PIN outside the pin range or equal to OUT_ONLY_PIN");
  end

  localparam logic [NUM_PINS-1:0] SLEW_RST = NUM_PINS'(1) << OUT_ONLY_PIN;

  // ************************************************************
  // State
  // ************************************************************
  pmx_state_t st;
  pmx_state_t next_st;
  pmx_fn_req_t [NUM_PINS-1:0] req_eff;
  logic [NUM_PINS-1:0] mux_out;
  logic [NUM_PINS-1:0] mux_oe;
  logic [NUM_PINS-1:0] mux_analog;
  logic [NUM_PINS-1:0] analog_active;
  logic [NUM_PINS-1:0] pull_on;
  logic [NUM_PINS-1:0] pull_dn;
  logic [DATA_W-1:0] read_value;
  int scl_pin;
  int sda_pin;

  // ************************************************************
  // Function request overlay
  // ************************************************************
  always_comb begin
    req_eff = fn_req;
    scl_pin = st.two_wire_pin_select ? PIN_B7 : PIN_A3;
    sda_pin = st.two_wire_pin_select ? PIN_B6 : PIN_A2;
    req_eff[scl_pin].en[SLOT_ALT2] = two_wire_en;
    req_eff[scl_pin].oe[SLOT_ALT2] = scl_oe;
    req_eff[scl_pin].out[SLOT_ALT2] = scl_out;
    req_eff[scl_pin].analog[SLOT_ALT2] = 1'b0;
    req_eff[sda_pin].en[SLOT_ALT2] = two_wire_en;
    req_eff[sda_pin].oe[SLOT_ALT2] = sda_oe;
    req_eff[sda_pin].out[SLOT_ALT2] = sda_out;
    req_eff[sda_pin].analog[SLOT_ALT2] = 1'b0;
    req_eff[PIN_A4].en[SLOT_ALT4] = st.debug_pin_en;
    req_eff[PIN_A4].oe[SLOT_ALT4] = debug_oe;
    req_eff[PIN_A4].out[SLOT_ALT4] = debug_out;
    req_eff[PIN_A4].analog[SLOT_ALT4] = 1'b0;
    req_eff[IN_ONLY_PIN].oe = '0;
  end

  assign scl_in = pad_in[scl_pin];
  assign sda_in = pad_in[sda_pin];
  assign debug_in = pad_in[PIN_A4];

  // ************************************************************
  // Per-pin arbitration and pad control
  // ************************************************************
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pmx_pin_arbiter u_arb (
      .clk_sys(clk_sys),
      .rst(rst),
      .req(req_eff[p]),
      .owner(pin_owner[p]),
      .owned(),
      .drive_out(mux_out[p]),
      .drive_oe(mux_oe[p]),
      .analog_owner(mux_analog[p])
    );

    always_comb begin
      analog_active[p] = mux_analog[p] | adc_en[p] | analog_compare_unit_en[p];
      pull_on[p] = st.pull_enable_bit[p] & ~mux_oe[p] & ~analog_active[p];
      pull_dn[p] = pull_on[p] & key_rise_edge[p];
      pad_ctl[p].out = mux_out[p];
      pad_ctl[p].oe = mux_oe[p];
      pad_ctl[p].pull_en = pull_on[p];
      pad_ctl[p].pull_down = pull_dn[p];
      pad_ctl[p].slew = st.slew_limit_bit[p] & mux_oe[p];
      pad_ctl[p].high_drive = st.drive_select_bit[p] & mux_oe[p];
    end

    // Comparator and converter taps are never excluded by each other
    assign adc_tap[p] = adc_en[p];
    assign analog_compare_unit_tap[p] = analog_compare_unit_en[p];

    pull_out_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      pad_ctl[p].oe |-> !pad_ctl[p].pull_en)
      else $error("pull device on while pin drives");
    pull_analog_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      (adc_en[p] || analog_compare_unit_en[p]) |-> !pad_ctl[p].pull_en)
      else $error("pull device on under analog control");
    pull_bit_on_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st.pull_enable_bit[p] && !pad_ctl[p].oe && !adc_en[p] && !analog_compare_unit_en[p]
       && !mux_analog[p]) |-> pad_ctl[p].pull_en)
      else $error("pull enable bit ignored on an input pin");
    pull_down_a: assert property (@(posedge clk_sys) disable iff (rst)
      pad_ctl[p].pull_en |-> (pad_ctl[p].pull_down == key_rise_edge[p]))
      else $error("pull direction does not follow rising key edge mode");
    slew_input_a: assert property (@(posedge clk_sys) disable iff (rst)
      !pad_ctl[p].oe |-> !pad_ctl[p].slew)
      else $error("slew limit active on an input pin");
    drive_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
      pad_ctl[p].oe |-> (pad_ctl[p].high_drive == st.drive_select_bit[p]
                         && pad_ctl[p].slew == st.slew_limit_bit[p]))
      else $error("drive or slew does not follow its bit on an output");
    both_taps_a: assert property (@(posedge clk_sys) disable iff (rst)
      (adc_en[p] && analog_compare_unit_en[p]) |-> (adc_tap[p] && analog_compare_unit_tap[p]))
      else $error("analog units excluded each other");
    pull_dir_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      pad_ctl[p].pull_down
      |-> pad_ctl[p].pull_en)
      else $error("pulldown selected without a pull device");
    drive_input_a: assert property (@(posedge clk_sys) disable iff (rst)
      !pad_ctl[p].oe
      |-> !pad_ctl[p].high_drive)
      else $error("high drive reported on an input pin");
    analog_owner_a: assert property (@(posedge clk_sys) disable iff (rst)
      mux_analog[p]
      |-> (!pad_ctl[p].pull_en && !pad_ctl[p].oe))
      else $error("analog owner left the pin driven or pulled");
    owner_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
      pad_ctl[p].oe
      |-> (req_eff[p].oe[pin_owner[p]] && req_eff[p].en[pin_owner[p]]))
      else $error("pin driven by a function that does not own it");
    owner_out_a: assert property (@(posedge clk_sys) disable iff (rst)
      pad_ctl[p].oe
      |-> (pad_ctl[p].out == req_eff[p].out[pin_owner[p]]))
      else $error("pin level not taken from its owner");
  end

  // ************************************************************
  // Register read mux
  // ************************************************************
  always_comb begin
    read_value = '0;
    unique case (reg_addr)
      PULL_A_ADDR: read_value = st.pull_enable_bit[DATA_W-1:0];
      PULL_B_ADDR: read_value = st.pull_enable_bit[NUM_PINS-1:DATA_W];
      SLEW_A_ADDR: read_value = st.slew_limit_bit[DATA_W-1:0];
      SLEW_B_ADDR: read_value = st.slew_limit_bit[NUM_PINS-1:DATA_W];
      DRIVE_A_ADDR: read_value = st.drive_select_bit[DATA_W-1:0];
      DRIVE_B_ADDR: read_value = st.drive_select_bit[NUM_PINS-1:DATA_W];
      SYS_OPT_TWO_ADDR: read_value[TWO_WIRE_SEL_BIT] = st.two_wire_pin_select;
      SYS_OPT_ONE_ADDR: read_value[DEBUG_PIN_EN_BIT] = st.debug_pin_en;
      PULL_ON_A_ADDR: read_value = pull_on[DATA_W-1:0];
      PULL_ON_B_ADDR: read_value = pull_on[NUM_PINS-1:DATA_W];
      PULL_DOWN_A_ADDR: read_value = pull_dn[DATA_W-1:0];
      PULL_DOWN_B_ADDR: read_value = pull_dn[NUM_PINS-1:DATA_W];
      default: read_value = '0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.rdata = reg_rd ? read_value : '0;
    if (reg_wr) begin
      // Each register byte touches only its own pins
      unique case (reg_addr)
        PULL_A_ADDR: next_st.pull_enable_bit[DATA_W-1:0] = reg_wdata;
        PULL_B_ADDR: next_st.pull_enable_bit[NUM_PINS-1:DATA_W] = reg_wdata;
        SLEW_A_ADDR: next_st.slew_limit_bit[DATA_W-1:0] = reg_wdata;
        SLEW_B_ADDR: next_st.slew_limit_bit[NUM_PINS-1:DATA_W] = reg_wdata;
        DRIVE_A_ADDR: next_st.drive_select_bit[DATA_W-1:0] = reg_wdata;
        DRIVE_B_ADDR: next_st.drive_select_bit[NUM_PINS-1:DATA_W] = reg_wdata;
        SYS_OPT_TWO_ADDR: next_st.two_wire_pin_select = reg_wdata[TWO_WIRE_SEL_BIT];
        SYS_OPT_ONE_ADDR: next_st.debug_pin_en = reg_wdata[DEBUG_PIN_EN_BIT];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st.pull_enable_bit <= PULL_RST;
      st.slew_limit_bit <= SLEW_RST;
      st.drive_select_bit <= DRIVE_RST;
      st.two_wire_pin_select <= TWO_WIRE_SEL_RST;
      st.debug_pin_en <= DEBUG_PIN_EN_RST;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;

  // ************************************************************
  // Checks
  // ************************************************************
  reset_state_a: assert property (@(posedge clk_sys)
    rst |=> (st.pull_enable_bit == PULL_RST && st.slew_limit_bit[OUT_ONLY_PIN]
                    && !st.drive_select_bit[OUT_ONLY_PIN] && st.debug_pin_en
                    && !st.two_wire_pin_select))
    else $error("control state wrong after reset");
  two_wire_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == SYS_OPT_TWO_ADDR)
    |=> (st.two_wire_pin_select == $past(reg_wdata[TWO_WIRE_SEL_BIT])))
    else $error("two-wire pin select not taken from write");
  two_wire_route_a: assert property (@(posedge clk_sys) disable iff (rst)
    (two_wire_en && !st.two_wire_pin_select && !req_eff[PIN_A3].en[SLOT_ALT4-1]
     && !req_eff[PIN_A3].en[SLOT_ALT4]) |-> (pad_ctl[PIN_A3].oe == scl_oe))
    else $error("two-wire clock not on its default pin");
  debug_owner_a: assert property (@(posedge clk_sys) disable iff (rst)
    st.debug_pin_en |-> (pin_owner[PIN_A4] == OWNER_W'(SLOT_ALT4)))
    else $error("debug function does not own port a pin four");
  pull_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == PULL_A_ADDR)
    |=> (st.pull_enable_bit
         == {$past(st.pull_enable_bit[NUM_PINS-1:DATA_W]), $past(reg_wdata)}))
    else $error("pull write disturbed other pins");
  read_one_cycle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data present without a read");

  // ************************************************************
  // Hold, reset, select, routing and read-path checks
  // ************************************************************
  pull_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && (reg_addr == PULL_A_ADDR || reg_addr == PULL_B_ADDR))
    |=> $stable(st.pull_enable_bit))
    else $error("pull bits changed without their own write");
  slew_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && (reg_addr == SLEW_A_ADDR || reg_addr == SLEW_B_ADDR))
    |=> $stable(st.slew_limit_bit))
    else $error("slew bits changed without their own write");
  drive_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && (reg_addr == DRIVE_A_ADDR || reg_addr == DRIVE_B_ADDR))
    |=> $stable(st.drive_select_bit))
    else $error("drive bits changed without their own write");
  reset_slew_drive_a: assert property (@(posedge clk_sys)
    rst
    |=> (st.slew_limit_bit == SLEW_RST && st.drive_select_bit == DRIVE_RST))
    else $error("slew or drive bits wrong after reset");
  two_wire_home_a: assert property (@(posedge clk_sys) disable iff (rst)
    (two_wire_en && !st.two_wire_pin_select)
    |-> (pin_owner[PIN_A3] >= OWNER_W'(SLOT_ALT2) && pin_owner[PIN_A2] >= OWNER_W'(SLOT_ALT2)))
    else $error("two-wire unit lost its default pins");
  two_wire_moved_a: assert property (@(posedge clk_sys) disable iff (rst)
    (two_wire_en && st.two_wire_pin_select)
    |-> (pin_owner[PIN_B7] >= OWNER_W'(SLOT_ALT2) && pin_owner[PIN_B6] >= OWNER_W'(SLOT_ALT2)))
    else $error("two-wire unit missing from its other pins");
  two_wire_left_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st.two_wire_pin_select && fn_req[PIN_A3].en == '0 && fn_req[PIN_A2].en == '0)
    |-> (pin_owner[PIN_A3] == OWNER_W'(SLOT_PORT) && pin_owner[PIN_A2] == OWNER_W'(SLOT_PORT)))
    else $error("two-wire unit still holds its default pins");
  two_wire_in_home_a: assert property (@(posedge clk_sys) disable iff (rst)
    !st.two_wire_pin_select
    |-> (scl_in == pad_in[PIN_A3] && sda_in == pad_in[PIN_A2]))
    else $error("two-wire inputs not taken from default pins");
  two_wire_in_moved_a: assert property (@(posedge clk_sys) disable iff (rst)
    st.two_wire_pin_select
    |-> (scl_in == pad_in[PIN_B7] && sda_in == pad_in[PIN_B6]))
    else $error("two-wire inputs not taken from other pins");
  debug_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!st.debug_pin_en && fn_req[PIN_A4].en == '0)
    |-> (pin_owner[PIN_A4] == OWNER_W'(SLOT_PORT)))
    else $error("debug function kept port a pin four");
  debug_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == SYS_OPT_ONE_ADDR)
    |=> (st.debug_pin_en == $past(reg_wdata[DEBUG_PIN_EN_BIT])))
    else $error("debug pin enable not taken from write");
  pull_on_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == PULL_ON_A_ADDR)
    |=> (reg_rdata == $past(pull_on[DATA_W-1:0])))
    else $error("pull-on status read wrong");
  pull_dn_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == PULL_DOWN_A_ADDR)
    |=> (reg_rdata == $past(pull_dn[DATA_W-1:0])))
    else $error("pulldown status read wrong");
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr > PULL_DOWN_B_ADDR)
    |=> (reg_rdata == '0))
    else $error("unmapped index returned data");
  in_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1
    |-> !pad_ctl[IN_ONLY_PIN].oe)
    else $error("input-only pin driven");
endmodule : pmx_pin_ctrl
`default_nettype wire

/* File: shared/pmx_pkg.sv */
// Constants and carrier types for the port pin control and sharing block.
// Assumes a 16-pin index space: port A pins 0..7, port B pins 8..15.
`default_nettype none
package pmx_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int NUM_PINS = 16;
  localparam int NUM_FUNCS = 5;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int OWNER_W = 3;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] PULL_A_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] PULL_B_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] SLEW_A_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] SLEW_B_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] DRIVE_A_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] DRIVE_B_ADDR = 4'h5;
  localparam logic [ADDR_W-1:0] SYS_OPT_TWO_ADDR = 4'h6;
  localparam logic [ADDR_W-1:0] SYS_OPT_ONE_ADDR = 4'h7;
  localparam logic [ADDR_W-1:0] PULL_ON_A_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] PULL_ON_B_ADDR = 4'h9;
  localparam logic [ADDR_W-1:0] PULL_DOWN_A_ADDR = 4'hA;
  localparam logic [ADDR_W-1:0] PULL_DOWN_B_ADDR = 4'hB;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int TWO_WIRE_SEL_BIT = 0;
  localparam int DEBUG_PIN_EN_BIT = 0;
  localparam logic [NUM_PINS-1:0] PULL_RST = 16'h0000;
  localparam logic [NUM_PINS-1:0] DRIVE_RST = 16'h0000;
  localparam logic TWO_WIRE_SEL_RST = 1'b0;
  localparam logic DEBUG_PIN_EN_RST = 1'b1;

  // ************************************************************
  // Pin and slot indices
  // ************************************************************
  localparam int PIN_A2 = 2;
  localparam int PIN_A3 = 3;
  localparam int PIN_A4 = 4;
  localparam int PIN_B6 = 14;
  localparam int PIN_B7 = 15;
  localparam int SLOT_PORT = 0;
  localparam int SLOT_ALT2 = 2;
  localparam int SLOT_ALT4 = 4;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [NUM_FUNCS-1:0] en;
    logic [NUM_FUNCS-1:0] oe;
    logic [NUM_FUNCS-1:0] out;
    logic [NUM_FUNCS-1:0] analog;
  } pmx_fn_req_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_en;
    logic pull_down;
    logic slew;
    logic high_drive;
  } pmx_pad_ctl_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] pull_enable_bit;
    logic [NUM_PINS-1:0] slew_limit_bit;
    logic [NUM_PINS-1:0] drive_select_bit;
    logic two_wire_pin_select;
    logic debug_pin_en;
    logic [DATA_W-1:0] rdata;
  } pmx_state_t;
endpackage : pmx_pkg
`default_nettype wire

/* File: rtl/pmx_pin_arbiter.sv */
// Fixed-priority owner selection for one shared pin.
// Assumes slot 0 is the port function and higher slots win.
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_arbiter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire pmx_pkg::pmx_fn_req_t req,
  output logic [pmx_pkg::OWNER_W-1:0] owner,
  output logic owned,
  output logic drive_out,
  output logic drive_oe,
  output logic analog_owner
);
  import pmx_pkg::*;

  // ************************************************************
  // Priority pick
  // ************************************************************
  always_comb begin
    owner = '0;
    owned = 1'b0;
    for (int i = 0; i < NUM_FUNCS; i++) begin
      if (req.en[i]) begin
        owner = i[OWNER_W-1:0];
        owned = 1'b1;
      end
    end
    analog_owner = owned & req.analog[owner];
    drive_oe = owned & req.oe[owner] & ~analog_owner;
    drive_out = drive_oe & req.out[owner];
  end

  // ************************************************************
  // Checks
  // ************************************************************
  top_slot_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.en[NUM_FUNCS-1] |-> (owner == OWNER_W'(NUM_FUNCS-1)))
    else $error("highest enabled function does not own the pin");
  lower_loses_a: assert property (@(posedge clk_sys) disable iff (rst)
    (req.en[1] && !req.en[2] && !req.en[3] && !req.en[4]) |-> (owner == 3'h1))
    else $error("port function kept the pin over an enabled alternate");
endmodule : pmx_pin_arbiter
`default_nettype wire

/* File: verif/pmx_pad_model.sv */
// Pad model: turns the pad controls back into pin levels.
// Assumes one clock; a pin neither driven nor pulled toggles each cycle.
`timescale 1ns/10ps
`default_nettype none
module pmx_pad_model (
  input wire logic clk_sys,
  input wire pmx_pkg::pmx_pad_ctl_t [pmx_pkg::NUM_PINS-1:0] pad_ctl,
  output var logic [pmx_pkg::NUM_PINS-1:0] pad_in
);
  import pmx_pkg::*;
  logic flip;
  initial flip = 1'b0;
  always @(posedge clk_sys) begin
    flip <= ~flip;
  end
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad_ctl[i].oe) begin
        pad_in[i] = pad_ctl[i].out;
      end else if (pad_ctl[i].pull_en) begin
        pad_in[i] = ~pad_ctl[i].pull_down;
      end else begin
        pad_in[i] = flip ^ i[0];
      end
    end
  end
endmodule : pmx_pad_model
`default_nettype wire

/* File: verif/test_pmx_pin_ctrl.sv */
// Self-checking bench for the pin control and sharing block.
// Assumes the pad model closes the loop from pad controls to pin levels.
`timescale 1ns/10ps
`default_nettype none
module test_pmx_pin_ctrl;
  import pmx_pkg::*;
  localparam int OUT_PIN = 13;
  localparam int IN_PIN = 5;
  logic clk_sys = 1'b0;
  logic rst, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  pmx_fn_req_t [NUM_PINS-1:0] fn_req;
  logic [NUM_PINS-1:0] key_rise_edge, adc_en, analog_compare_unit_en, pad_in, adc_tap, analog_compare_unit_tap;
  logic two_wire_en, scl_oe, scl_out, sda_oe, sda_out, debug_oe, debug_out;
  logic scl_in, sda_in, debug_in;
  pmx_pad_ctl_t [NUM_PINS-1:0] pad_ctl;
  logic [NUM_PINS-1:0][OWNER_W-1:0] pin_owner;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  pmx_pin_ctrl #(.OUT_ONLY_PIN(OUT_PIN), .IN_ONLY_PIN(IN_PIN)) dut (.clk_sys(clk_sys),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fn_req(fn_req), .key_rise_edge(key_rise_edge), .adc_en(adc_en),
    .analog_compare_unit_en(analog_compare_unit_en), .two_wire_en(two_wire_en), .scl_oe(scl_oe), .scl_out(scl_out),
    .sda_oe(sda_oe), .sda_out(sda_out), .debug_oe(debug_oe), .debug_out(debug_out),
    .pad_in(pad_in), .scl_in(scl_in), .sda_in(sda_in), .debug_in(debug_in),
    .adc_tap(adc_tap), .analog_compare_unit_tap(analog_compare_unit_tap), .pad_ctl(pad_ctl), .pin_owner(pin_owner));
  pmx_pad_model pads (.clk_sys(clk_sys), .pad_ctl(pad_ctl), .pad_in(pad_in));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  function automatic int top(input int m);
    top = 0;
    for (int s = 0; s < NUM_FUNCS; s++) begin
      if (m[s]) top = s;
    end
  endfunction : top
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_reset;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] exp [8];
    exp = '{8'h00, 8'h00, 8'h00, 8'h01 << (OUT_PIN - 8), 8'h00, 8'h00, 8'h00, 8'h01};
    for (int a = 0; a < 8; a++) begin
      rd(a[ADDR_W-1:0], d);
      check(d, exp[a]);
    end
    @(posedge clk_sys);
    #1;
    check(reg_rdata, 8'h00);
    rd(4'hF, d);
    check(d, 8'h00);
    for (int i = 0; i < NUM_PINS; i++) begin
      check({pad_ctl[i].oe, pad_ctl[i].pull_en}, 2'b00);
    end
    check(pin_owner[PIN_A4], SLOT_ALT4);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_pull;
    logic [DATA_W-1:0] d;
    wr(PULL_A_ADDR, 8'hFF);
    wr(PULL_B_ADDR, 8'hFF);
    for (int i = 0; i < NUM_PINS; i++) begin
      check({pad_ctl[i].pull_en, pad_ctl[i].pull_down}, 2'b10);
    end
    @(posedge clk_sys);
    key_rise_edge[1] <= 1'b1;
    fn_req[2].en[0] <= 1'b1;
    fn_req[2].oe[0] <= 1'b1;
    adc_en[3] <= 1'b1;
    analog_compare_unit_en[9] <= 1'b1;
    fn_req[6].en[3] <= 1'b1;
    fn_req[6].analog[3] <= 1'b1;
    #1;
    check({pad_ctl[1].pull_down, pad_ctl[0].pull_down}, 2'b10);
    check(pad_ctl[2].pull_en, 1'b0);
    check({pad_ctl[3].pull_en, pad_ctl[9].pull_en, pad_ctl[6].pull_en}, 3'b000);
    rd(PULL_ON_A_ADDR, d);
    check(d, 8'hB3);
    rd(PULL_DOWN_A_ADDR, d);
    check(d, 8'h02);
    rd(PULL_ON_B_ADDR, d);
    check(d, 8'hFD);
    @(posedge clk_sys);
    key_rise_edge <= '0;
    adc_en <= '0;
    analog_compare_unit_en <= '0;
    fn_req <= '0;
    wr(PULL_A_ADDR, 8'h00);
    wr(PULL_B_ADDR, 8'h00);
    $display("test_pull done");
  endtask : test_pull
  task automatic test_priority;
    logic [NUM_FUNCS-1:0] outs;
    outs = 5'h0A;
    wr(SLEW_B_ADDR, 8'h04);
    wr(DRIVE_B_ADDR, 8'h04);
    for (int m = 1; m < 32; m++) begin
      @(posedge clk_sys);
      fn_req[10] <= '{m[4:0], 5'h1F, 5'h0A, 5'h00};
      fn_req[11] <= '{m[4:0], 5'h1F, 5'h0A, 5'h00};
      #1;
      check(pin_owner[10], top(m));
      check({pad_ctl[10].oe, pad_ctl[10].out}, {1'b1, outs[top(m)]});
      check({pad_ctl[10].slew, pad_ctl[10].high_drive}, 2'b11);
      check({pad_ctl[11].slew, pad_ctl[11].high_drive}, 2'b00);
    end
    @(posedge clk_sys);
    fn_req[10].oe <= '0;
    fn_req[IN_PIN] <= '{5'h01, 5'h01, 5'h01, 5'h00};
    #1;
    check({pad_ctl[10].oe, pad_ctl[10].slew, pad_ctl[10].high_drive}, 3'b000);
    check(pad_ctl[IN_PIN].oe, 1'b0);
    @(posedge clk_sys);
    fn_req <= '0;
    adc_en[0] <= 1'b1;
    analog_compare_unit_en[0] <= 1'b1;
    #1;
    check({adc_tap[0], analog_compare_unit_tap[0]}, 2'b11);
    $display("test_priority done");
  endtask : test_priority
  task automatic test_two_wire;
    logic [DATA_W-1:0] d;
    @(posedge clk_sys);
    two_wire_en <= 1'b1;
    scl_oe <= 1'b1;
    scl_out <= 1'b1;
    sda_oe <= 1'b1;
    sda_out <= 1'b0;
    #1;
    check({pin_owner[PIN_A3], pin_owner[PIN_A2]}, {3'(SLOT_ALT2), 3'(SLOT_ALT2)});
    check({pad_ctl[PIN_A3].out, pad_ctl[PIN_A2].out, scl_in, sda_in}, 4'hA);
    wr(SYS_OPT_TWO_ADDR, 8'h01);
    check({pin_owner[PIN_B7], pin_owner[PIN_A3]}, {3'(SLOT_ALT2), 3'(SLOT_PORT)});
    check({pad_ctl[PIN_B7].out, pad_ctl[PIN_B6].out, scl_in, sda_in}, 4'hA);
    rd(SYS_OPT_TWO_ADDR, d);
    check(d, 8'h01);
    @(posedge clk_sys);
    debug_oe <= 1'b1;
    debug_out <= 1'b1;
    #1;
    check({pad_ctl[PIN_A4].oe, debug_in}, 2'b11);
    wr(SYS_OPT_ONE_ADDR, 8'h00);
    check(pin_owner[PIN_A4], SLOT_PORT);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check({pin_owner[PIN_A4], pin_owner[PIN_A3]}, {3'(SLOT_ALT4), 3'(SLOT_ALT2)});
    $display("test_two_wire done");
  endtask : test_two_wire
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    fn_req = '0;
    key_rise_edge = '0;
    adc_en = '0;
    analog_compare_unit_en = '0;
    {two_wire_en, scl_oe, scl_out, sda_oe, sda_out, debug_oe, debug_out} = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    test_pull();
    test_priority();
    test_two_wire();
    finish_test();
  end
endmodule : test_pmx_pin_ctrl
`default_nettype wire
